// ===== logic/ulms_top.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - set framing_fault when a received stop bit samples low; read clears
// - after a framing fault, bad stop bit becomes the next start bit
// - queued faults show in line_status_reg when their character is at head
// - set parity_fault on parity mismatch with even/odd selection; read clears
// - set overrun_fault at once on overrun; read of line_status_reg clears
// - no FIFO: new character overwrites unread holding register, overrun
// - FIFO full: new character dropped, queue untouched, overrun
// - rx_char_ready while holding register or queue holds data
// - infrared with ir_modem_status_select set: modem status reads 30h
// - loopback: modem inputs cut, status driven from modem_control_reg bits
// - modem_change_event when irq enable set and any delta bit set
// - delta bits clear on reset, read, mode change with select low
// - upper modem status bits show live DCD, RI, DSR, CTS
// - carrier_detect_delta set on any DCD change; read clears
// - ring_trailing_edge set only on RI high-to-low; read clears
// - set_ready_delta and clear_to_send_delta set on DSR/CTS change
// - offset 07h: scratch_store if extended bit 0, else aux_status_control
// - aux_status_control meaning follows mode; cleared by hardware reset
// - aux bit 2 clears on transmitter soft reset and after end-of-tx char
// - aux bit 6 clears on transmitter soft reset or host write of 1
// - aux bits 0,1,4,5 clear on receiver soft reset
// - line status bits 3:1 sticky; clear on reset, rx soft reset, read
module ulms_top #(
	parameter int CLKS_PER_BIT = ulms_pkg::BIT_CLKS_DEF,
	parameter int DATA_BITS    = ulms_pkg::DATA_BITS_DEF,
	parameter int RXQ_DEPTH    = ulms_pkg::RXQ_DEPTH_DEF
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RSTN,
	input  wire logic [2:0]  ADDR,
	input  wire logic        RD_STB,
	input  wire logic        WR_STB,
	input  wire logic [7:0]  WDATA,
	output logic      [7:0]  RDATA,
	input  wire logic        RXD,
	input  wire logic        DCD,
	input  wire logic        RI,
	input  wire logic        DSR,
	input  wire logic        CTS,
	input  wire logic        FIFO_EN,
	input  wire logic        PARITY_EN,
	input  wire logic        PARITY_EVEN,
	input  wire logic        EXT_MODE,
	input  wire logic        LOOPBACK,
	input  wire logic [3:0]  MODEM_CONTROL_REG,
	input  wire logic        IR_MODE,
	input  wire logic        IR_MODEM_STATUS_SELECT,
	input  wire logic [2:0]  OP_MODE,
	input  wire logic        MODEM_CHANGE_IRQ_EN,
	input  wire logic        TX_SOFT_RST,
	input  wire logic        RX_SOFT_RST,
	input  wire logic        EOT_SENT,
	input  wire logic [7:0]  ASC_SET,
	input  wire logic        TX_IDLE,
	input  wire logic        TX_HOLD_EMPTY,
	output logic             RX_CHAR_READY,
	output logic             MODEM_CHANGE_EVENT,
	output logic [7:0]       AUX_STATUS_CONTROL
);
	import ulms_pkg::*;

	localparam int AW = $clog2(RXQ_DEPTH);
	localparam int EW = DATA_BITS + 2;

	// address hit for a strobe
	function automatic logic hit(input logic stb, input logic [2:0] a,
		input logic [2:0] off);
		hit = stb && (a == off);
	endfunction

	logic [EW-1:0]         mem [RXQ_DEPTH];
	logic [AW-1:0]         wr_ptr_r;
	logic [AW-1:0]         rd_ptr_r;
	logic [AW:0]           count_r;
	logic [AW:0]           count_nxt;
	logic [AW:0]           limit;
	logic                  head_seen_r;
	logic                  fe_r;
	logic                  pe_r;
	logic                  oe_r;
	logic                  rxd_meta_r;
	logic                  rxd_sync_r;
	logic                  char_done;
	logic [DATA_BITS-1:0]  char_data;
	logic                  char_pe;
	logic                  char_fe;
	logic                  push;
	logic                  overrun;
	logic                  overwrite;
	logic                  pop;
	logic                  rd_lsr;
	logic                  rd_msr;
	logic                  rd_asc;
	logic                  wr_spc;
	logic                  head_new;
	logic [EW-1:0]         head;
	logic [3:0]            pin_meta_r;
	logic [3:0]            pin_sync_r;
	logic [3:0]            live;
	logic [3:0]            live_r;
	logic [3:0]            delta_r;
	logic [3:0]            delta_set;
	logic [3:0]            delta_nxt;
	logic                  delta_clr;
	logic [2:0]            mode_r;
	logic [7:0]            scratch_r;
	logic [7:0]            asc_nxt;
	logic [7:0]            rd_mux;
	logic                  modem_change_event_r;

	// receive line into the core clock
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rxd_meta_r <= 1'b1;
			rxd_sync_r <= 1'b1;
		end
		else
		begin
			rxd_meta_r <= RXD;
			rxd_sync_r <= rxd_meta_r;
		end
	end

	ulms_rx_frame #(
		.CLKS_PER_BIT (CLKS_PER_BIT),
		.DATA_BITS    (DATA_BITS)
	) u_rx_frame (
		.clk          (CORE_CLK),
		.rst_n        (RSTN),
		.rxd          (rxd_sync_r),
		.parity_en    (PARITY_EN),
		.parity_even  (PARITY_EVEN),
		.char_done    (char_done),
		.char_data    (char_data),
		.char_pe      (char_pe),
		.char_fe      (char_fe)
	);

	// host access decode
	assign rd_lsr = hit(RD_STB, ADDR, OFF_LSR);
	assign rd_msr = hit(RD_STB, ADDR, OFF_MSR);
	assign rd_asc = hit(RD_STB, ADDR, OFF_SCRATCH) && EXT_MODE;
	assign wr_spc = hit(WR_STB, ADDR, OFF_SCRATCH);
	assign pop    = hit(RD_STB, ADDR, OFF_RX_DATA) && (count_r != '0);

	// queue depth one acts as the holding register
	assign limit     = FIFO_EN ? (AW+1)'(RXQ_DEPTH) : (AW+1)'(1);
	assign push      = char_done && (count_r < limit);
	assign overrun   = char_done && (count_r >= limit);
	assign overwrite = overrun && !FIFO_EN;
	assign head      = mem[rd_ptr_r];
	assign head_new  = (count_r != '0) && !head_seen_r;

	// entries: parity fault, framing fault, data
	always_ff @(posedge CORE_CLK)
	begin
		if (push)
			mem[wr_ptr_r] <= {char_pe, char_fe, char_data};
		else if (overwrite)
			mem[rd_ptr_r] <= {char_pe, char_fe, char_data};
	end

	always_comb
	begin
		count_nxt = count_r;
		if (push && !pop)
			count_nxt = count_r + 1'b1;
		else if (pop && !push)
			count_nxt = count_r - 1'b1;
	end

	// pointers, fill level and head tracking
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			wr_ptr_r      <= '0;
			rd_ptr_r      <= '0;
			count_r       <= '0;
			head_seen_r   <= 1'b0;
			RX_CHAR_READY <= 1'b0;
		end
		else if (RX_SOFT_RST)
		begin
			wr_ptr_r      <= '0;
			rd_ptr_r      <= '0;
			count_r       <= '0;
			head_seen_r   <= 1'b0;
			RX_CHAR_READY <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			count_r       <= count_nxt;
			RX_CHAR_READY <= count_nxt != '0;
			if (pop || overwrite)
				head_seen_r <= 1'b0;
			else if (count_r != '0)
				head_seen_r <= 1'b1;
		end
	end

	// sticky line faults, set beats the read clear
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			fe_r <= 1'b0;
			pe_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else if (RX_SOFT_RST)
		begin
			fe_r <= 1'b0;
			pe_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else
		begin
			fe_r <= (head_new && head[EW-2]) || (fe_r && !rd_lsr);
			pe_r <= (head_new && head[EW-1]) || (pe_r && !rd_lsr);
			oe_r <= overrun || (oe_r && !rd_lsr);
		end
	end

	// modem pins into the core clock
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			pin_meta_r <= 4'h0;
			pin_sync_r <= 4'h0;
		end
		else
		begin
			pin_meta_r <= {DCD, RI, DSR, CTS};
			pin_sync_r <= pin_meta_r;
		end
	end

	// loopback swaps pins for control bits
	assign live = LOOPBACK ? {MODEM_CONTROL_REG[MCR_DCD],
		MODEM_CONTROL_REG[MCR_RI], MODEM_CONTROL_REG[MCR_DTR],
		MODEM_CONTROL_REG[MCR_RTS]} : pin_sync_r;

	// change detection and clear sources
	always_comb
	begin
		delta_set = 4'h0;
		delta_set[MSR_DCD_DELTA] = live[3] ^ live_r[3];
		delta_set[MSR_RING_EDGE] = live_r[2] && !live[2];
		delta_set[MSR_DSR_DELTA] = live[1] ^ live_r[1];
		delta_set[MSR_CTS_DELTA] = live[0] ^ live_r[0];
		delta_clr = rd_msr ||
			((OP_MODE != mode_r) && !IR_MODEM_STATUS_SELECT);
		delta_nxt = delta_set | (delta_r & ~{4{delta_clr}});
	end

	// modem status state and event
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			live_r  <= 4'h0;
			delta_r <= 4'h0;
			mode_r  <= 3'h0;
			modem_change_event_r <= 1'b0;
		end
		else
		begin
			live_r  <= live;
			delta_r <= delta_nxt;
			mode_r  <= OP_MODE;
			modem_change_event_r <= MODEM_CHANGE_IRQ_EN && (delta_nxt != 4'h0);
		end
	end

	assign MODEM_CHANGE_EVENT = modem_change_event_r;

	// aux register next value, hardware sets win
	always_comb
	begin
		asc_nxt = AUX_STATUS_CONTROL;
		if (wr_spc && EXT_MODE)
		begin
			asc_nxt[ASC_EOT] = WDATA[ASC_EOT];
			if (WDATA[ASC_TX_UNDER])
				asc_nxt[ASC_TX_UNDER] = 1'b0;
			if (WDATA[ASC_RX_ACTIVE])
				asc_nxt[ASC_RX_ACTIVE] = 1'b0;
		end
		if (rd_asc)
			asc_nxt[ASC_RX_WDOG] = 1'b0;
		if (pop)
			asc_nxt[ASC_RX_TIMEOUT] = 1'b0;
		if (EOT_SENT || TX_SOFT_RST)
			asc_nxt[ASC_EOT] = 1'b0;
		if (TX_SOFT_RST)
			asc_nxt[ASC_TX_UNDER] = 1'b0;
		if (RX_SOFT_RST)
			asc_nxt = asc_nxt & ~ASC_RXR_MASK;
		asc_nxt = asc_nxt | (ASC_SET & ASC_HW_MASK);
	end

	// shared offset: scratch or aux by extended bit
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			scratch_r          <= SCRATCH_RST;
			AUX_STATUS_CONTROL <= ASC_RST;
		end
		else
		begin
			if (wr_spc && !EXT_MODE)
				scratch_r <= WDATA;
			AUX_STATUS_CONTROL <= asc_nxt;
		end
	end

	// read data select
	always_comb
	begin
		rd_mux = 8'h00;
		case (ADDR)
			OFF_RX_DATA:
				rd_mux = (count_r != '0) ? head[7:0] : 8'h00;
			OFF_LSR:
			begin
				rd_mux[LSR_RX_READY] = count_r != '0;
				rd_mux[LSR_OVERRUN]  = oe_r;
				rd_mux[LSR_PARITY]   = pe_r;
				rd_mux[LSR_FRAMING]  = fe_r;
				rd_mux[LSR_TX_READY] = TX_HOLD_EMPTY;
				rd_mux[LSR_TX_EMPTY] = TX_IDLE;
			end
			OFF_MSR:
				rd_mux = (IR_MODE && IR_MODEM_STATUS_SELECT) ? MSR_IR_VALUE :
					{live_r, delta_r};
			OFF_SCRATCH:
				rd_mux = EXT_MODE ? AUX_STATUS_CONTROL : scratch_r;
			default:
				rd_mux = 8'h00;
		endcase
	end

	// read data register, holds between reads
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			RDATA <= 8'h00;
		else if (RD_STB)
			RDATA <= rd_mux;
	end

	a_overrun_flag: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		overrun && !RX_SOFT_RST |=> oe_r)
		else $error("overrun not flagged");
	a_fifo_drop: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		overrun && FIFO_EN && !pop && !RX_SOFT_RST |=> count_r == $past(count_r))
		else $error("queue changed on overrun");
	a_rx_ready: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		push && !RX_SOFT_RST |=> RX_CHAR_READY)
		else $error("ready missing after push");
	a_msr_ir_value: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		rd_msr && IR_MODE && IR_MODEM_STATUS_SELECT |=> RDATA == 8'h30)
		else $error("infrared modem status not 30h");
	a_dcd_delta: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		live[3] != live_r[3] |=> delta_r[MSR_DCD_DELTA])
		else $error("dcd change lost");
	a_ring_edge: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		$rose(delta_r[MSR_RING_EDGE]) |-> $fell(live_r[2]))
		else $error("ring edge without falling ri");
	a_msr_rd_clear: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		rd_msr && delta_set == 4'h0 |=> delta_r == 4'h0)
		else $error("delta bits not cleared by read");
	a_modem_event: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		delta_r != 4'h0 && $past(MODEM_CHANGE_IRQ_EN) |-> MODEM_CHANGE_EVENT)
		else $error("modem event missing");
	a_txur_w1c: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		wr_spc && EXT_MODE && WDATA[ASC_TX_UNDER] && !ASC_SET[ASC_TX_UNDER]
		|=> !AUX_STATUS_CONTROL[ASC_TX_UNDER])
		else $error("underrun bit not cleared by write");

endmodule
`default_nettype wire

// ===== inc/ulms_pkg.sv
`default_nettype none
package ulms_pkg;

	// clock and default line rate
	localparam int CORE_CLK_HZ   = 100_000_000;
	localparam int BAUD_RATE_DEF = 115_200;
	localparam int BIT_CLKS_DEF  = CORE_CLK_HZ / BAUD_RATE_DEF;
	localparam int DATA_BITS_DEF = 8;
	localparam int RXQ_DEPTH_DEF = 16;

	// register offsets
	localparam logic [2:0] OFF_RX_DATA = 3'h0;
	localparam logic [2:0] OFF_LSR     = 3'h5;
	localparam logic [2:0] OFF_MSR     = 3'h6;
	localparam logic [2:0] OFF_SCRATCH = 3'h7;

	// line_status_reg fields
	localparam int LSR_RX_READY = 0;
	localparam int LSR_OVERRUN  = 1;
	localparam int LSR_PARITY   = 2;
	localparam int LSR_FRAMING  = 3;
	localparam int LSR_TX_READY = 5;
	localparam int LSR_TX_EMPTY = 6;

	// modem_line_status fields and fixed infrared value
	localparam int MSR_CTS_DELTA  = 0;
	localparam int MSR_DSR_DELTA  = 1;
	localparam int MSR_RING_EDGE  = 2;
	localparam int MSR_DCD_DELTA  = 3;
	localparam logic [7:0] MSR_IR_VALUE = 8'h30;

	// modem_control_reg bits used in loopback
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_RI  = 2;
	localparam int MCR_DCD = 3;

	// aux_status_control fields and masks
	localparam int ASC_RX_TIMEOUT = 0;
	localparam int ASC_EOT        = 2;
	localparam int ASC_RX_WDOG    = 4;
	localparam int ASC_RX_ACTIVE  = 5;
	localparam int ASC_TX_UNDER   = 6;
	localparam logic [7:0] ASC_HW_MASK  = 8'h73;
	localparam logic [7:0] ASC_RXR_MASK = 8'h33;
	localparam logic [7:0] ASC_RST      = 8'h00;
	localparam logic [7:0] SCRATCH_RST  = 8'h00;

	// receiver framing states, gray along the path
	typedef enum logic [2:0] {
		RX_IDLE   = 3'b000,
		RX_START  = 3'b001,
		RX_DATA   = 3'b011,
		RX_PARITY = 3'b010,
		RX_STOP   = 3'b110
	} ulms_rx_state_type;

endpackage
`default_nettype wire

// ===== logic/ulms_rx_frame.sv
`timescale 1ns/10ps
`default_nettype none
module ulms_rx_frame #(
	parameter int CLKS_PER_BIT = ulms_pkg::BIT_CLKS_DEF,
	parameter int DATA_BITS    = ulms_pkg::DATA_BITS_DEF
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 rxd,
	input  wire logic                 parity_en,
	input  wire logic                 parity_even,
	output logic                      char_done,
	output logic [DATA_BITS-1:0]      char_data,
	output logic                      char_pe,
	output logic                      char_fe
);
	import ulms_pkg::*;

	localparam int CW = $clog2(CLKS_PER_BIT + 1);
	localparam logic [CW-1:0] FULL = CW'(CLKS_PER_BIT - 1);
	localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2 - 1);
	localparam logic [3:0]    LAST = 4'(DATA_BITS - 1);

	ulms_rx_state_type     state_r;
	logic [CW-1:0]         cnt_r;
	logic [3:0]            bit_r;
	logic [DATA_BITS-1:0]  shift_r;
	logic                  par_r;
	logic                  pe_r;

	// framing, mid-bit sampling, resync on a low stop bit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r   <= RX_IDLE;
			cnt_r     <= '0;
			bit_r     <= 4'h0;
			shift_r   <= '0;
			par_r     <= 1'b0;
			pe_r      <= 1'b0;
			char_done <= 1'b0;
			char_data <= '0;
			char_pe   <= 1'b0;
			char_fe   <= 1'b0;
		end
		else
		begin
			char_done <= 1'b0;
			case (state_r)
				RX_IDLE:
					if (!rxd)
					begin
						state_r <= RX_START;
						cnt_r   <= HALF;
					end
				RX_START:
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else if (!rxd)
					begin
						state_r <= RX_DATA;
						cnt_r   <= FULL;
						bit_r   <= 4'h0;
						par_r   <= 1'b0;
					end
					else
						state_r <= RX_IDLE; // glitch, not a start
				RX_DATA:
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else
					begin
						shift_r <= {rxd, shift_r[DATA_BITS-1:1]};
						par_r   <= par_r ^ rxd;
						cnt_r   <= FULL;
						bit_r   <= bit_r + 1'b1;
						if (bit_r == LAST)
						begin
							state_r <= parity_en ? RX_PARITY : RX_STOP;
							pe_r    <= 1'b0;
						end
					end
				RX_PARITY:
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else
					begin
						pe_r    <= par_r ^ rxd ^ ~parity_even;
						cnt_r   <= FULL;
						state_r <= RX_STOP;
					end
				RX_STOP:
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else
					begin
						char_done <= 1'b1;
						char_data <= shift_r;
						char_pe   <= pe_r;
						char_fe   <= !rxd;
						if (!rxd)
						begin
							// low stop bit taken as next start
							state_r <= RX_DATA;
							cnt_r   <= FULL;
							bit_r   <= 4'h0;
							par_r   <= 1'b0;
						end
						else
							state_r <= RX_IDLE;
					end
				default:
					state_r <= RX_IDLE;
			endcase
		end
	end

	a_resync_after_fe: assert property (@(posedge clk) disable iff (!rst_n)
		char_done && char_fe |-> state_r == RX_DATA && bit_r == 4'h0)
		else $error("no resync after framing fault");

endmodule
`default_nettype wire

// ===== verification/ulms_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// far-side modem: serial frames on rxd, modem lines as plain levels
module ulms_far_model #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic clk,
	output logic      rxd,
	output logic      dcd,
	output logic      ri,
	output logic      dsr,
	output logic      cts
);
	// line idles high, modem lines start low to match the synchronisers
	initial
	begin
		rxd = 1'b1;
		{dcd, ri, dsr, cts} = 4'h0;
	end

	// one bit time on the line, entered and left at a falling edge
	task automatic put_bit(input logic b);
		rxd = b;
		repeat (BIT_CLKS) @(negedge clk);
	endtask

	// lsb first; no_start chains onto a low stop bit already sent
	task automatic send(input logic [7:0] d, input logic pen,
		input logic peven, input logic bad_par, input logic stop,
		input logic no_start);
		logic p;
		p = (peven ? ^d : ~^d) ^ bad_par;
		if (!no_start)
			put_bit(1'b0);
		for (int i = 0; i < 8; i++)
			put_bit(d[i]);
		if (pen)
			put_bit(p);
		put_bit(stop); // a low stop bit leaves the line low for chaining
	endtask

	// modem lines as {dcd, ri, dsr, cts}
	task automatic pins(input logic [3:0] v);
		{dcd, ri, dsr, cts} = v;
	endtask
endmodule
`default_nettype wire

// ===== verification/uart_line_modem_status_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module uart_line_modem_status_tb_top;
	import ulms_pkg::*;
	localparam int BITC = 16;
	localparam int QD   = 4;
	logic       clk = 1'b0;
	logic       rst_n, rd_stb, wr_stb, rxd, dcd, ri, dsr, cts;
	logic       fifo_en, par_en, par_even, ext_mode, loopback;
	logic       ir_mode, ir_sel, irq_en, tx_srst, rx_srst, eot_sent;
	logic       tx_idle, tx_hold_empty, rx_ready, mevent;
	logic [2:0] addr, op_mode;
	logic [3:0] modem_control_reg;
	logic [7:0] wdata, rdata, asc_set, aux, v;
	int         mismatches  = 0;
	int         checks_done = 0;

	// 100 MHz core clock
	always #5 clk = ~clk;

	ulms_far_model #(.BIT_CLKS(BITC)) fm (.clk(clk), .rxd(rxd), .dcd(dcd),
		.ri(ri), .dsr(dsr), .cts(cts));

	ulms_top #(.CLKS_PER_BIT(BITC), .RXQ_DEPTH(QD)) DUT (
		.CORE_CLK(clk), .RSTN(rst_n), .ADDR(addr), .RD_STB(rd_stb),
		.WR_STB(wr_stb), .WDATA(wdata), .RDATA(rdata), .RXD(rxd),
		.DCD(dcd), .RI(ri), .DSR(dsr), .CTS(cts), .FIFO_EN(fifo_en),
		.PARITY_EN(par_en), .PARITY_EVEN(par_even), .EXT_MODE(ext_mode),
		.LOOPBACK(loopback), .MODEM_CONTROL_REG(modem_control_reg), .IR_MODE(ir_mode),
		.IR_MODEM_STATUS_SELECT(ir_sel), .OP_MODE(op_mode),
		.MODEM_CHANGE_IRQ_EN(irq_en), .TX_SOFT_RST(tx_srst),
		.RX_SOFT_RST(rx_srst), .EOT_SENT(eot_sent), .ASC_SET(asc_set),
		.TX_IDLE(tx_idle), .TX_HOLD_EMPTY(tx_hold_empty),
		.RX_CHAR_READY(rx_ready), .MODEM_CHANGE_EVENT(mevent),
		.AUX_STATUS_CONTROL(aux));

	// counts and verdict, the single end of the run
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// bus cycles: strobe for one edge, data looked at after it lands
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		addr = a;
		rd_stb = 1'b1;
		tick(1);
		rd_stb = 1'b0;
		tick(1);
		d = rdata;
	endtask

	task automatic rdc(input string nm, input logic [2:0] a,
		input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(nm, e, d);
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr_stb = 1'b1;
		tick(1);
		wr_stb = 1'b0;
		tick(1);
	endtask

	task automatic rx(input logic [7:0] d, input logic bp,
		input logic st, input logic ns);
		fm.send(d, par_en, par_even, bp, st, ns);
		tick(4);
	endtask

	task automatic modem(input logic [3:0] p);
		fm.pins(p);
		tick(6);
	endtask

	// watchdog, far beyond the expected few thousand cycles
	initial
	begin
		#300_000;
		mismatches++;
		give_verdict();
	end

	// main sequence
	initial
	begin
		{rst_n, rd_stb, wr_stb, ext_mode, loopback, ir_mode} = 6'h00;
		{ir_sel, tx_srst, rx_srst, eot_sent, fifo_en} = 5'h00;
		{par_en, par_even, irq_en, tx_idle, tx_hold_empty} = 5'h1E;
		{addr, op_mode, modem_control_reg, wdata, asc_set} = 26'h0;
		tick(6);
		rst_n = 1'b1;
		tick(4);
		rd(OFF_MSR, v);
		// reset values and the shared offset 7
		chk("aux port", 8'h00, aux);
		rdc("scratch", OFF_SCRATCH, 8'h00);
		ext_mode = 1'b1;
		rdc("aux", OFF_SCRATCH, 8'h00);
		rdc("line status", OFF_LSR, 8'h40);
		ext_mode = 1'b0;
		wr(OFF_SCRATCH, 8'hA5);
		ext_mode = 1'b1;
		wr(OFF_SCRATCH, 8'h04);
		rdc("aux", OFF_SCRATCH, 8'h04);
		ext_mode = 1'b0;
		rdc("scratch", OFF_SCRATCH, 8'hA5);
		// aux clears: end of tx, tx soft reset, write one, rx soft reset
		eot_sent = 1'b1;
		tick(1);
		eot_sent = 1'b0;
		tick(1);
		chk("aux eot", 8'h00, aux);
		ext_mode = 1'b1;
		wr(OFF_SCRATCH, 8'h04);
		tx_srst = 1'b1;
		asc_set = 8'h73;
		tick(1);
		tx_srst = 1'b0;
		asc_set = 8'h00;
		tick(1);
		chk("aux tx reset", 8'h73, aux);
		wr(OFF_SCRATCH, 8'h40);
		chk("aux write one", 8'h33, aux);
		rx_srst = 1'b1;
		tick(1);
		rx_srst = 1'b0;
		asc_set = 8'h40;
		tick(1);
		asc_set = 8'h00;
		tx_srst = 1'b1;
		tick(1);
		tx_srst = 1'b0;
		tick(1);
		chk("aux rx reset", 8'h00, aux);
		// holding register, even then odd parity
		rx(8'h5A, 1'b0, 1'b1, 1'b0);
		chk("ready", 8'h01, {7'h0, rx_ready});
		rdc("line status", OFF_LSR, 8'h41);
		rdc("rx data", OFF_RX_DATA, 8'h5A);
		chk("ready", 8'h00, {7'h0, rx_ready});
		par_even = 1'b0;
		rx(8'h3C, 1'b1, 1'b1, 1'b0);
		rdc("parity", OFF_LSR, 8'h45);
		rdc("parity", OFF_LSR, 8'h41);
		rdc("rx data", OFF_RX_DATA, 8'h3C);
		// overrun without queue: newest character kept
		rx(8'h11, 1'b0, 1'b1, 1'b0);
		rx(8'h22, 1'b0, 1'b1, 1'b0);
		rdc("overrun", OFF_LSR, 8'h43);
		rdc("rx data", OFF_RX_DATA, 8'h22);
		rdc("line status", OFF_LSR, 8'h40);
		// queue full: extra character dropped
		fifo_en = 1'b1;
		for (int i = 0; i <= QD; i++)
			rx(8'h30 + 8'(i), 1'b0, 1'b1, 1'b0);
		rdc("overrun", OFF_LSR, 8'h43);
		for (int i = 0; i < QD; i++)
			rdc("queue data", OFF_RX_DATA, 8'h30 + 8'(i));
		chk("ready", 8'h00, {7'h0, rx_ready});
		// framing fault behind a good character, then a chained one
		rx(8'h81, 1'b0, 1'b1, 1'b0);
		fm.send(8'h96, par_en, par_even, 1'b0, 1'b0, 1'b0);
		rx(8'hC3, 1'b0, 1'b1, 1'b1);
		rdc("fault at head", OFF_LSR, 8'h41);
		rdc("rx data", OFF_RX_DATA, 8'h81);
		tick(2);
		rdc("framing", OFF_LSR, 8'h49);
		rdc("rx data", OFF_RX_DATA, 8'h96);
		rdc("resync data", OFF_RX_DATA, 8'hC3);
		rdc("line status", OFF_LSR, 8'h40);
		// receiver soft reset drops the queue and a pending fault
		rx(8'h55, 1'b1, 1'b1, 1'b0);
		rx_srst = 1'b1;
		tick(1);
		rx_srst = 1'b0;
		rdc("rx soft reset", OFF_LSR, 8'h40);
		chk("ready", 8'h00, {7'h0, rx_ready});
		// modem lines {dcd, ri, dsr, cts}, deltas and event
		modem(4'b1000);
		chk("event", 8'h01, {7'h0, mevent});
		rdc("modem", OFF_MSR, 8'h88);
		tick(2);
		chk("event", 8'h00, {7'h0, mevent});
		modem(4'b1100);
		rdc("ring rise", OFF_MSR, 8'hC0);
		modem(4'b1000);
		rdc("ring fall", OFF_MSR, 8'h84);
		modem(4'b1011);
		rdc("dsr cts", OFF_MSR, 8'hB3);
		irq_en = 1'b0;
		modem(4'b1000);
		chk("event off", 8'h00, {7'h0, mevent});
		op_mode = 3'h1;
		tick(3);
		rdc("mode change", OFF_MSR, 8'h80);
		// loopback: pins cut off, control bits drive status
		loopback = 1'b1;
		modem_control_reg = 4'b0101;
		modem(4'b0000);
		rdc("loopback", OFF_MSR, 8'h6A);
		modem(4'b1111);
		rdc("loopback", OFF_MSR, 8'h60);
		loopback = 1'b0;
		modem(4'b0000);
		rd(OFF_MSR, v);
		// infrared fixed value, then normal view
		ir_mode = 1'b1;
		ir_sel = 1'b1;
		modem(4'b1001);
		rdc("ir select", OFF_MSR, MSR_IR_VALUE);
		ir_sel = 1'b0;
		rdc("ir normal", OFF_MSR, 8'h90);
		// mode change with select high keeps the deltas
		ir_sel = 1'b1;
		modem(4'b1000);
		op_mode = 3'h2;
		tick(3);
		ir_sel = 1'b0;
		rdc("mode keep", OFF_MSR, 8'h81);
		give_verdict();
	end
endmodule
`default_nettype wire
